// ---- design/pc_seq_regs.svh ----
// constants for the program-flow sequencer
`ifndef PC_SEQ_REGS_SVH
`define PC_SEQ_REGS_SVH
`define PC_RESET_VECTOR 12'h000
`define PC_SOFT_VECTOR 12'h002
`define PC_NUM_IRQ 10
`define PC_STACK_DEPTH 8
`define PC_PAGE_RESET 2'h0
`define PC_PAGE_LSB 5
`define PC_PAGE_MSB 6
`endif

// ---- design/pc_seq_pkg.sv ----
// types for the program-flow sequencer
package pc_seq_pkg;
	typedef enum logic [2:0] {
		OP_NEXT,
		OP_NEAR_JUMP,
		OP_NEAR_CALL,
		OP_FAR_JUMP,
		OP_FAR_CALL,
		OP_RETURN,
		OP_SOFT_INT,
		OP_PCL_WRITE
	} flow_op_t;
	typedef struct packed {
		logic valid;
		flow_op_t op;
		logic [11:0] target;
		logic [7:0] pcl_data;
	} flow_cmd_t;
	typedef struct packed {
		logic [11:0] pc;
		logic [7:0] pc_low_byte;
		logic [2:0] depth;
		logic busy;
	} flow_state_t;
endpackage

// ---- design/return_stack.sv ----
// circular return-address stack
`timescale 1ns/100ps
module return_stack #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 12
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [WIDTH-1:0] i_data,
	output logic [WIDTH-1:0] o_top,
	output logic [$clog2(DEPTH)-1:0] o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] ptr;
	logic [AW-1:0] count;
	wire [AW-1:0] top_idx = ptr - AW'(1);
	assign o_top = mem[top_idx];
	assign o_count = count;
	// pointer wraps so a ninth push overwrites the oldest, no overflow flag
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ptr <= '0;
			count <= '0;
		end
		else if (i_push)
		begin
			mem[ptr] <= i_data; // RL8
			ptr <= ptr + AW'(1); // RL17
			if (count != AW'(DEPTH - 1))
				count <= count + AW'(1);
		end
		else if (i_pop)
		begin
			ptr <= top_idx; // RL8
			if (count != '0)
				count <= count - AW'(1);
		end
	end
endmodule // return_stack

// ---- design/pc_sequencer.sv ----
// program counter and flow sequencer
// What this block does
// RL1 - twelve-bit program counter covering 4K words
// RL2 - any reset loads counter with zero
// RL3 - hardware interrupt branches to its own vector
// RL4 - software interrupt branches to address 0x002
// RL5 - near call/jump carry ten-bit target
// RL6 - near upper bits from status bits six, five
// RL7 - return restores all twelve counter bits
// RL8 - eight-deep stack; calls, interrupts push, returns pop
// RL9 - one cycle each, flow changes take two
// RL10 - far call/jump reach whole space
// RL11 - page instruction sets page select persistently
// RL12 - ten interrupt requests, each own vector
// RL13 - single-word instructions advance one address
// RL14 - counter increments each cycle unless changed; holds for the one flush cycle after each flow change
// RL15 - low byte readable/writable, upper nibble hidden
// RL16 - counter bits 11:10 on near and low-byte updates come from page select
// RL17 - stack wraps, ninth push overwrites oldest
// RL18 - lowest vector wins among pending interrupts
`timescale 1ns/100ps
`include "pc_seq_regs.svh"
module pc_sequencer #(
	parameter int NUM_IRQ = `PC_NUM_IRQ,
	parameter int STACK_DEPTH = `PC_STACK_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input pc_seq_pkg::flow_cmd_t i_cmd,
	input wire logic i_page_write,
	input wire logic [1:0] i_page_data,
	input wire logic [NUM_IRQ-1:0] i_irq,
	input wire logic i_irq_enable,
	output pc_seq_pkg::flow_state_t o_state,
	output logic [1:0] o_program_page_select,
	output logic o_irq_taken,
	output logic [3:0] o_irq_index
);
	import pc_seq_pkg::*;
	// vectors in source order; index 0 is lowest address
	localparam logic [11:0] VEC [10] = '{12'h003, 12'h006, 12'h009, 12'h00C, 12'h00F,
		12'h012, 12'h015, 12'h018, 12'h01E, 12'h021}; // RL3 RL12

	logic [11:0] pc;
	logic [1:0] program_page_select;
	logic busy;
	logic [11:0] next_pc;
	logic push;
	logic pop;
	logic [11:0] push_data;
	logic [11:0] stack_top;
	logic [2:0] depth;

	// priority pick of pending interrupt
	logic irq_any;
	logic [3:0] irq_sel;
	always_comb
	begin
		irq_any = 1'b0;
		irq_sel = 4'h0;
		for (int i = NUM_IRQ - 1; i >= 0; i--)
			if (i_irq[i])
			begin
				irq_any = 1'b1;
				irq_sel = 4'(i); // RL18
			end
	end

	// interrupts are taken only between instructions, never in a flush slot
	wire take_irq = irq_any && i_irq_enable && !busy;
	wire cmd_live = i_cmd.valid && !busy && !take_irq;
	wire [11:0] pc_inc = pc + 12'h001; // RL13 RL14
	wire [11:0] near_target = {program_page_select, i_cmd.target[9:0]}; // RL5 RL6 RL16
	wire [11:0] pcl_target = {program_page_select, 2'b00, i_cmd.pcl_data}; // RL15 RL16
	wire is_call = i_cmd.op == OP_NEAR_CALL || i_cmd.op == OP_FAR_CALL;
	wire is_soft = i_cmd.op == OP_SOFT_INT;

	always_comb
	begin
		next_pc = pc_inc; // RL14
		push = 1'b0;
		pop = 1'b0;
		push_data = pc_inc;
		if (take_irq)
		begin
			next_pc = VEC[irq_sel]; // RL3
			push = 1'b1; // RL8
			push_data = pc;
		end
		else if (cmd_live)
		begin
			unique case (i_cmd.op)
				OP_NEXT: next_pc = pc_inc;
				OP_NEAR_JUMP, OP_NEAR_CALL: next_pc = near_target; // RL5
				OP_FAR_JUMP, OP_FAR_CALL: next_pc = i_cmd.target; // RL10
				OP_RETURN:
				begin
					next_pc = stack_top; // RL7
					pop = 1'b1;
				end
				OP_SOFT_INT: next_pc = `PC_SOFT_VECTOR; // RL4
				OP_PCL_WRITE: next_pc = pcl_target;
			endcase
			push = is_call || is_soft; // RL8
		end
		else if (busy)
			next_pc = pc;
	end

	wire flow_change = take_irq || (cmd_live && i_cmd.op != OP_NEXT); // RL9

	return_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(12)
	) u_stack (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_push(push),
		.i_pop(pop),
		.i_data(push_data),
		.o_top(stack_top),
		.o_count(depth)
	);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			pc <= `PC_RESET_VECTOR; // RL2
			program_page_select <= `PC_PAGE_RESET;
			busy <= 1'b0;
			o_irq_taken <= 1'b0;
			o_irq_index <= 4'h0;
		end
		else
		begin
			pc <= next_pc; // RL1
			busy <= flow_change; // RL9
			o_irq_taken <= take_irq;
			o_irq_index <= take_irq ? irq_sel : o_irq_index;
			if (i_page_write)
				program_page_select <= i_page_data; // RL11
		end
	end

	assign o_state = '{pc: pc, pc_low_byte: pc[7:0], depth: depth, busy: busy}; // RL15
	assign o_program_page_select = program_page_select;
endmodule // pc_sequencer

// ---- test/pc_seq_props.sv ----
// assertions bound to the flow sequencer
`timescale 1ns/100ps
module pc_seq_props #(
	parameter int NUM_IRQ = 10
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input pc_seq_pkg::flow_cmd_t i_cmd,
	input wire logic i_page_write,
	input wire logic [1:0] i_page_data,
	input wire logic [NUM_IRQ-1:0] i_irq,
	input wire logic i_irq_enable,
	input pc_seq_pkg::flow_state_t o_state,
	input wire logic [1:0] o_program_page_select,
	input wire logic o_irq_taken,
	input wire logic [3:0] o_irq_index
);
	import pc_seq_pkg::*;
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	wire pend = i_irq_enable && |i_irq;
	wire go = i_cmd.valid && !o_state.busy && !pend;
	wire [NUM_IRQ-1:0] low = i_irq & (~i_irq + 1'b1);
	wire [2:0] op = i_cmd.op;
	a_reset_zero: assert property ($fell(i_rst) |-> o_state.pc == 12'h000)
		else $error("pc not cleared");
	a_step_one: assert property (!o_state.busy && !i_cmd.valid && !pend
		|=> o_state.pc == $past(o_state.pc) + 12'h001) else $error("no step");
	a_near_page: assert property (go && (op == OP_NEAR_JUMP || op == OP_NEAR_CALL)
		|=> o_state.pc == {$past(o_program_page_select), $past(i_cmd.target[9:0])})
		else $error("bad near target");
	a_far_reach: assert property (go && (op == OP_FAR_JUMP || op == OP_FAR_CALL)
		|=> o_state.pc == $past(i_cmd.target)) else $error("bad far target");
	a_two_cycle: assert property (go && op != OP_NEXT
		|=> o_state.busy ##1 !o_state.busy) else $error("not two cycles");
	a_irq_vector: assert property (o_irq_taken |-> o_state.pc == (o_irq_index < 4'h8 ?
		12'h003 * (o_irq_index + 12'h001) : 12'h003 * (o_irq_index + 12'h002)))
		else $error("bad vector");
	a_irq_lowest: assert property (pend && !o_state.busy
		|=> o_irq_taken && ($past(low) >> o_irq_index) == 1'b1) else $error("bad irq pick");
	a_page_write: assert property (i_page_write
		|=> o_program_page_select == $past(i_page_data)) else $error("page lost");
	c_irq: cover property (o_irq_taken);
	c_call: cover property (go && op == OP_NEAR_CALL);
	c_ret: cover property (go && op == OP_RETURN);
endmodule // pc_seq_props
bind pc_sequencer pc_seq_props #(.NUM_IRQ(NUM_IRQ)) pc_seq_props_inst (.*);

// ---- test/prog_mem_model.sv ----
// program memory model feeding flow commands
`timescale 1ns/100ps
module prog_mem_model (
	input wire logic [11:0] i_pc,
	input wire logic i_en,
	output pc_seq_pkg::flow_cmd_t o_cmd
);
	import pc_seq_pkg::*;
	flow_cmd_t mem [4096];
	assign o_cmd = i_en ? mem[i_pc] : '0;
endmodule // prog_mem_model

// ---- test/program_counter_sequencer_tb.sv ----
// self-checking bench for the flow sequencer
`timescale 1ns/100ps
module program_counter_sequencer_tb;
	import pc_seq_pkg::*;
	logic i_clk = 0, i_rst = 1, i_page_write = 0, i_irq_enable = 0;
	logic [1:0] i_page_data = 2'h0;
	logic [9:0] i_irq = 10'h000;
	flow_cmd_t i_cmd;
	flow_state_t o_state;
	logic [1:0] o_program_page_select;
	logic o_irq_taken;
	logic [3:0] o_irq_index;
	int n_errors = 0, num_checks = 0;
	initial forever #50 i_clk = ~i_clk;
	pc_sequencer pc_sequencer_inst (.*);
	prog_mem_model prog_mem_model_inst (.i_pc(o_state.pc), .i_en(!i_rst), .o_cmd(i_cmd));
	task chk(input string s, input logic [11:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s exp %h seen %h", s, exp, got);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge i_clk);
		#10;
	endtask
	task rst;
		@(posedge i_clk) i_rst <= 1;
		for (int a = 0; a < 4096; a++) prog_mem_model_inst.mem[a] = '0;
		repeat (12) @(posedge i_clk);
		i_rst <= 0;
	endtask
	task put(input logic [11:0] a, input flow_op_t op, input logic [11:0] t);
		prog_mem_model_inst.mem[a] = '{1'b1, op, t, 8'h5A};
	endtask
	task t_irq;
		for (int k = 0; k < 10; k++)
		begin
			rst;
			i_irq <= 10'h3FF << k;
			i_irq_enable <= 1;
			step(1);
			chk("vec", o_state.pc, k < 8 ? 3 * (k + 1) : 3 * (k + 2));
			chk("idx", o_irq_index, k);
			chk("taken", o_irq_taken, 12'h001);
			@(posedge i_clk) i_irq_enable <= 0;
			i_irq <= 10'h000;
		end
	endtask
	task t_call_ret;
		rst;
		i_page_write <= 1;
		i_page_data <= 2'h2;
		put(12'h001, OP_NEAR_CALL, 12'h305);
		put(12'hB05, OP_RETURN, 12'h000);
		step(1);
		chk("step", o_state.pc, 12'h001);
		chk("page", o_program_page_select, 12'h002);
		@(posedge i_clk) i_page_write <= 0;
		#10;
		chk("near", o_state.pc, 12'hB05);
		chk("push", o_state.depth, 12'h001);
		step(2);
		chk("ret", o_state.pc, 12'h002);
	endtask
	task t_far;
		rst;
		put(12'h000, OP_FAR_JUMP, 12'hFFE);
		step(4);
		chk("wrap", o_state.pc, 12'h000);
	endtask
	task t_soft;
		rst;
		put(12'h000, OP_SOFT_INT, 12'h000);
		put(12'h002, OP_PCL_WRITE, 12'h000);
		step(1);
		chk("soft", o_state.pc, 12'h002);
		chk("busy", o_state.busy, 12'h001);
		step(2);
		chk("pcl", o_state.pc_low_byte, 12'h05A);
	endtask
	// nine nested calls, then nine returns: the ninth pop sees the overwritten slot
	task t_wrap;
		rst;
		for (int i = 0; i < 9; i++)
			put(12'(16 * i), OP_NEAR_CALL, 12'(16 * (i + 1)));
		put(12'h090, OP_RETURN, 12'h000);
		for (int j = 1; j < 9; j++)
			put(12'(16 * j + 1), OP_RETURN, 12'h000);
		step(18);
		chk("depth", o_state.depth, 12'h007);
		step(17);
		chk("wrap pop", o_state.pc, 12'h081);
	endtask
	task close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_errors++;
		close_out;
	end
	initial
	begin
		rst;
		t_irq;
		t_call_ret;
		t_far;
		t_soft;
		t_wrap;
		close_out;
	end
endmodule // program_counter_sequencer_tb
